// ==== inc/vmc_pkg.sv ====
`default_nettype none

package vmc_pkg;

	// Register bus geometry
	localparam int REG_AW    = 12;
	localparam int REG_DW    = 32;
	localparam int WORD_LSB  = 2;
	localparam int PAGE_LSB  = 8;

	// Register byte offsets
	localparam logic [11:0] OFS_CTRL       = 12'h000;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h004;
	localparam logic [11:0] OFS_IRQ_MASK   = 12'h008;
	localparam logic [11:0] OFS_COND       = 12'h00C;
	localparam logic [11:0] OFS_LR_BASE    = 12'h100;

	// Control register fields
	localparam int BIT_EN    = 0;
	localparam int BIT_UIE   = 1;
	localparam int BIT_LRENP = 2;
	localparam int BIT_NP    = 3;
	localparam int BIT_G0E   = 4;
	localparam int BIT_G0D   = 5;
	localparam int BIT_G1E   = 6;
	localparam int BIT_G1D   = 7;
	localparam int CNT_LSB   = 27;
	localparam int CNT_W     = 5;

	localparam logic [31:0] CTRL_WMASK = 32'hF80000FF;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;

	// Condition, status and mask layout follows the control enable bits
	localparam int          COND_W     = 8;
	localparam logic [7:0]  COND_RESET = 8'h00;
	localparam logic [23:0] COND_PAD   = 24'h000000;

	// List register entry layout
	localparam int          LR_ID_W      = 10;
	localparam int          LR_STATE_LSB = 28;
	localparam int          LR_STATE_W   = 2;
	localparam int          PEND_BIT     = 0;
	localparam int          ACT_BIT      = 1;
	localparam logic [1:0]  ST_INVALID   = 2'h0;
	localparam logic [1:0]  ST_PENDING   = 2'h1;
	localparam logic [1:0]  ST_ACTIVE    = 2'h2;

	// Defaults
	localparam int          DEF_NUM_LR      = 4;
	localparam logic [9:0]  DEF_SPURIOUS_ID = 10'h3FF;

endpackage

`default_nettype wire

// ==== logic/vmc_lr_store.sv ====
`timescale 1ns/1ns
`default_nettype none

module vmc_lr_store #(
	parameter int NUM_LR = vmc_pkg::DEF_NUM_LR,
	parameter int IDX_W  = 2
) (
	// Clock and reset
	input  wire logic                                         ref_clk_i,
	input  wire logic                                         rst_i,
	// Software write and read
	input  wire logic                                         sw_we_i,
	input  wire logic [IDX_W-1:0]                             sw_idx_i,
	input  wire logic [vmc_pkg::LR_STATE_W-1:0]               sw_state_i,
	input  wire logic [vmc_pkg::LR_ID_W-1:0]                  sw_id_i,
	input  wire logic                                         rd_i,
	input  wire logic [IDX_W-1:0]                             rd_idx_i,
	output logic      [31:0]                                  rd_data_o,
	// Hardware state update, one per entry
	input  wire logic [NUM_LR-1:0]                            hw_we_i,
	input  wire logic [NUM_LR-1:0][vmc_pkg::LR_STATE_W-1:0]   hw_state_i,
	// Entry contents
	output logic      [NUM_LR-1:0][vmc_pkg::LR_STATE_W-1:0]   state_o,
	output logic      [NUM_LR-1:0][vmc_pkg::LR_ID_W-1:0]      id_o
);

	typedef struct packed {
		logic [NUM_LR-1:0][vmc_pkg::LR_STATE_W-1:0] state;
		logic [NUM_LR-1:0][vmc_pkg::LR_ID_W-1:0]    id;
		logic [31:0]                                rdata;
	} vmc_store_type;

	vmc_store_type r;
	vmc_store_type next_r;

	// Software write first, hardware state update wins over it
	always_comb begin
		next_r = r;
		if (sw_we_i) begin
			next_r.state[sw_idx_i] = sw_state_i;
			next_r.id[sw_idx_i]    = sw_id_i;
		end
		for (int i = 0; i < NUM_LR; i++) begin
			if (hw_we_i[i]) begin
				next_r.state[i] = hw_state_i[i];
			end
		end
		if (rd_i) begin
			next_r.rdata = '0;
			next_r.rdata[vmc_pkg::LR_STATE_LSB +: vmc_pkg::LR_STATE_W] = r.state[rd_idx_i];
			next_r.rdata[vmc_pkg::LR_ID_W-1:0] = r.id[rd_idx_i];
		end
	end

	// State register
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign rd_data_o = r.rdata;
	assign state_o   = r.state;
	assign id_o      = r.id;

endmodule

`default_nettype wire

// ==== logic/vmc_maint_ctrl.sv ====
// Summary of operation
// - Group 0 disabled enable raises maintenance
// - Group 0 enabled enable raises maintenance
// - No pending entries raises maintenance when enabled
// - Nonzero unmatched EOI count raises maintenance
// - Zero or one valid entry raises maintenance
// - Global enable off silences maint_irq_o; sticky status and irq_o still follow the conditions
// - Global enable off blocks virtual interrupts
// - Global enable off makes acknowledge return spurious
// - Unmatched EOI counter increments, wraps 31 to 0
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module vmc_maint_ctrl #(
	parameter int         NUM_LR      = vmc_pkg::DEF_NUM_LR,
	parameter logic [9:0] SPURIOUS_ID = vmc_pkg::DEF_SPURIOUS_ID
) (
	// Clock and reset
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_i,
	// Register port
	input  wire logic [vmc_pkg::REG_AW-1:0]   reg_addr_i,
	input  wire logic [vmc_pkg::REG_DW-1:0]   reg_wdata_i,
	input  wire logic                         reg_wr_i,
	input  wire logic                         reg_rd_i,
	output logic      [vmc_pkg::REG_DW-1:0]   reg_rdata_o,
	// Virtual machine view
	input  wire logic                         vm_group0_enable_i,
	input  wire logic                         vm_group1_enable_i,
	input  wire logic                         vm_ack_rd_i,
	input  wire logic                         vm_alias_ack_rd_i,
	output logic      [vmc_pkg::LR_ID_W-1:0]  vm_ack_data_o,
	output logic                              vm_ack_valid_o,
	output logic                              vm_irq_o,
	// End of interrupt from the virtual machine
	input  wire logic                         eoi_valid_i,
	input  wire logic [vmc_pkg::LR_ID_W-1:0]  eoi_id_i,
	input  wire logic                         apr_active_i,
	// Interrupt outputs
	output logic                              maint_irq_o,
	output logic                              irq_o
);

	localparam int IDX_W = (NUM_LR > 1) ? $clog2(NUM_LR) : 1;
	localparam int LRSEL_W = vmc_pkg::PAGE_LSB - vmc_pkg::WORD_LSB + 1;

	typedef struct packed {
		logic [31:0]                    ctrl;
		logic [vmc_pkg::COND_W-1:0]     status;
		logic [vmc_pkg::COND_W-1:0]     mask;
		logic [vmc_pkg::COND_W-1:0]     cond_q;
		logic                           maint;
		logic                           virq;
		logic [31:0]                    rdata;
		logic                           rd_lr;
		logic [vmc_pkg::LR_ID_W-1:0]    ack_data;
		logic                           ack_valid;
	} vmc_state_type;

	vmc_state_type r;
	vmc_state_type next_r;

	// List register contents
	logic [NUM_LR-1:0][vmc_pkg::LR_STATE_W-1:0] lr_state;
	logic [NUM_LR-1:0][vmc_pkg::LR_ID_W-1:0]    lr_id;
	logic [NUM_LR-1:0][vmc_pkg::LR_STATE_W-1:0] hw_state;
	logic [NUM_LR-1:0]                          hw_we;
	logic [31:0]                                lr_rdata;

	// Per-entry views
	logic [NUM_LR-1:0] pend;
	logic [NUM_LR-1:0] act;
	logic [NUM_LR-1:0] vld;
	logic [NUM_LR-1:0] eoi_hit;
	logic [NUM_LR-1:0] ack_cand;
	logic [NUM_LR-1:0] eoi_one;
	logic [NUM_LR-1:0] ack_one;
	logic [NUM_LR-1:0] eoi_sel;
	logic [NUM_LR-1:0] ack_sel;

	// Decoded control and derived conditions
	logic                          en;
	logic [vmc_pkg::COND_W-1:0]    cond;
	logic [vmc_pkg::CNT_W-1:0]     cnt;
	logic [vmc_pkg::CNT_W-1:0]     next_cnt;
	logic                          unmatched;
	logic                          ack_req;
	logic                          ack_take;
	logic [vmc_pkg::LR_ID_W-1:0]   ack_id;
	logic                          lr_hit;
	logic [IDX_W-1:0]              lr_idx;
	logic                          underflow;

	// Register access decode and next values
	logic                          ctrl_wr;
	logic                          status_wr;
	logic                          mask_wr;
	logic                          lr_wr;
	logic                          lr_rd;
	logic [vmc_pkg::COND_W-1:0]    status_clr;
	logic [vmc_pkg::COND_W-1:0]    cond_rise;
	logic [vmc_pkg::COND_W-1:0]    next_status;
	logic                          next_maint;
	logic                          next_virq;
	logic [vmc_pkg::LR_ID_W-1:0]   ack_word;
	logic [31:0]                   rd_word;

	assign en  = r.ctrl[vmc_pkg::BIT_EN];
	assign cnt = r.ctrl[vmc_pkg::CNT_LSB +: vmc_pkg::CNT_W];

	// List register window decode
	assign lr_hit = (reg_addr_i[vmc_pkg::REG_AW-1:vmc_pkg::PAGE_LSB]
		== vmc_pkg::OFS_LR_BASE[vmc_pkg::REG_AW-1:vmc_pkg::PAGE_LSB])
		&& ({1'b0, reg_addr_i[vmc_pkg::PAGE_LSB-1:vmc_pkg::WORD_LSB]}
		< LRSEL_W'(NUM_LR));
	assign lr_idx = reg_addr_i[vmc_pkg::WORD_LSB +: IDX_W];

	// Entry flags, EOI match and acknowledge candidates
	genvar g;
	generate
		for (g = 0; g < NUM_LR; g++) begin : gen_entry
			assign pend[g]     = lr_state[g][vmc_pkg::PEND_BIT];
			assign act[g]      = lr_state[g][vmc_pkg::ACT_BIT];
			assign vld[g]      = |lr_state[g];
			assign eoi_hit[g]  = act[g] && (lr_id[g] == eoi_id_i);
			assign ack_cand[g] = pend[g] && !act[g];
			assign eoi_sel[g]  = eoi_valid_i && eoi_one[g];
			assign ack_sel[g]  = ack_take && ack_one[g];
			assign hw_we[g]    = eoi_sel[g] || ack_sel[g];
			// EOI drops the active bit, acknowledge moves pending to active
			assign hw_state[g] = eoi_sel[g] ? (lr_state[g] & ~vmc_pkg::ST_ACTIVE)
				: vmc_pkg::ST_ACTIVE;
		end
	endgenerate

	// Lowest-index entry of each candidate set
	assign eoi_one = eoi_hit & (~eoi_hit + NUM_LR'(1));
	assign ack_one = ack_cand & (~ack_cand + NUM_LR'(1));

	// Identifier of the acknowledged entry
	always_comb begin
		ack_id = '0;
		for (int i = 0; i < NUM_LR; i++) begin
			if (ack_one[i]) begin
				ack_id = ack_id | lr_id[i];
			end
		end
	end

	// Acknowledge only takes an entry while the interface is enabled
	assign ack_req  = vm_ack_rd_i || vm_alias_ack_rd_i;
	assign ack_take = ack_req && en && (|ack_cand);

	// EOI with no matching entry that still retires an active priority
	assign unmatched = eoi_valid_i && !(|eoi_hit) && apr_active_i;

	// Zero or one valid entry: clearing the lowest set bit leaves nothing
	assign underflow = ((vld & (vld - NUM_LR'(1))) == '0);

	// Maintenance conditions, one per enable bit
	always_comb begin
		cond = vmc_pkg::COND_RESET;
		cond[vmc_pkg::BIT_G0D] = r.ctrl[vmc_pkg::BIT_G0D] && !vm_group0_enable_i;
		cond[vmc_pkg::BIT_G0E] = r.ctrl[vmc_pkg::BIT_G0E] && vm_group0_enable_i;
		cond[vmc_pkg::BIT_NP] = r.ctrl[vmc_pkg::BIT_NP] && !(|pend);
		cond[vmc_pkg::BIT_LRENP] = r.ctrl[vmc_pkg::BIT_LRENP] && (cnt != '0);
		cond[vmc_pkg::BIT_UIE] = r.ctrl[vmc_pkg::BIT_UIE] && underflow;
		cond[vmc_pkg::BIT_G1D] = r.ctrl[vmc_pkg::BIT_G1D] && !vm_group1_enable_i;
		cond[vmc_pkg::BIT_G1E] = r.ctrl[vmc_pkg::BIT_G1E] && vm_group1_enable_i;
	end

	// Register strobes, exact word addresses for control, status and mask; the list window ignores address bits 1:0
	assign ctrl_wr   = reg_wr_i && (reg_addr_i == vmc_pkg::OFS_CTRL);
	assign status_wr = reg_wr_i && (reg_addr_i == vmc_pkg::OFS_IRQ_STATUS);
	assign mask_wr   = reg_wr_i && (reg_addr_i == vmc_pkg::OFS_IRQ_MASK);
	assign lr_wr     = reg_wr_i && lr_hit;
	assign lr_rd     = reg_rd_i && lr_hit;

	// Counter: software write sets the base, an unmatched EOI still counts
	always_comb begin
		next_cnt = cnt;
		if (ctrl_wr) begin
			next_cnt = reg_wdata_i[vmc_pkg::CNT_LSB +: vmc_pkg::CNT_W];
		end
		if (unmatched) begin
			// Field is five bits wide, so the top value wraps to zero
			next_cnt = next_cnt + vmc_pkg::CNT_W'(1);
		end
	end

	// Sticky status: write one to clear, a rising condition in the same cycle wins
	assign status_clr  = status_wr ? reg_wdata_i[vmc_pkg::COND_W-1:0] : vmc_pkg::COND_RESET;
	assign cond_rise   = cond & ~r.cond_q;
	assign next_status = (r.status & ~status_clr) | cond_rise;

	// Maintenance level: any enabled condition, silenced by the global enable
	assign next_maint = en && (|cond);

	// Virtual interrupt only while the interface is enabled
	assign next_virq = en && (|ack_cand);

	// Acknowledge answer: a real entry only while enabled, else the spurious id
	assign ack_word = ack_take ? ack_id : SPURIOUS_ID;

	// Read multiplexer for the control-side registers
	always_comb begin
		rd_word = '0;
		case (reg_addr_i)
			vmc_pkg::OFS_CTRL: begin
				rd_word = r.ctrl;
			end
			vmc_pkg::OFS_IRQ_STATUS: begin
				rd_word = {vmc_pkg::COND_PAD, r.status};
			end
			vmc_pkg::OFS_IRQ_MASK: begin
				rd_word = {vmc_pkg::COND_PAD, r.mask};
			end
			vmc_pkg::OFS_COND: begin
				rd_word = {vmc_pkg::COND_PAD, cond};
			end
			default: begin
				// Unmapped words read zero; the list window comes from the store
				rd_word = '0;
			end
		endcase
	end

	// Next state of all control, status and answer registers
	always_comb begin
		next_r = r;
		next_r.ack_valid = 1'b0;
		next_r.rd_lr     = lr_rd;

		// Control word: reserved bits stay zero, the count follows its own logic
		if (ctrl_wr) begin
			next_r.ctrl = reg_wdata_i & vmc_pkg::CTRL_WMASK;
		end
		next_r.ctrl[vmc_pkg::CNT_LSB +: vmc_pkg::CNT_W] = next_cnt;

		// Mask register
		if (mask_wr) begin
			next_r.mask = reg_wdata_i[vmc_pkg::COND_W-1:0];
		end

		// Status and the previous conditions for edge detection
		next_r.status = next_status;
		next_r.cond_q = cond;

		// Interrupt levels, registered one clock after their causes
		next_r.maint = next_maint;
		next_r.virq  = next_virq;

		// Acknowledge answer one cycle after the read, data held until the next
		if (ack_req) begin
			next_r.ack_valid = 1'b1;
			next_r.ack_data  = ack_word;
		end

		// Register reads: data stand in the cycle after the strobe
		if (reg_rd_i) begin
			next_r.rdata = rd_word;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.ctrl <= vmc_pkg::CTRL_RESET;
			r.status <= vmc_pkg::COND_RESET;
			r.mask <= vmc_pkg::COND_RESET;
			r.cond_q <= vmc_pkg::COND_RESET;
		end else begin
			r <= next_r;
		end
	end

	// List register storage
	vmc_lr_store #(
		.NUM_LR (NUM_LR),
		.IDX_W  (IDX_W)
	) u_store (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.sw_we_i    (lr_wr),
		.sw_idx_i   (lr_idx),
		.sw_state_i (reg_wdata_i[vmc_pkg::LR_STATE_LSB +: vmc_pkg::LR_STATE_W]),
		.sw_id_i    (reg_wdata_i[vmc_pkg::LR_ID_W-1:0]),
		.rd_i       (lr_rd),
		.rd_idx_i   (lr_idx),
		.rd_data_o  (lr_rdata),
		.hw_we_i    (hw_we),
		.hw_state_i (hw_state),
		.state_o    (lr_state),
		.id_o       (lr_id)
	);

	// Outputs
	assign reg_rdata_o    = r.rd_lr ? lr_rdata : r.rdata;
	assign vm_ack_data_o  = r.ack_data;
	assign vm_ack_valid_o = r.ack_valid;
	assign vm_irq_o       = r.virq;
	assign maint_irq_o    = r.maint;
	assign irq_o          = |(r.status & r.mask);

endmodule

`default_nettype wire

// ==== tb/vmc_maint_ctrl_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none

module vmc_maint_ctrl_checker #(
	parameter logic [9:0] SPURIOUS_ID = 10'h3FF
) (
	// Clock and reset
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_i,
	// Register port
	input  wire logic [vmc_pkg::REG_AW-1:0]   reg_addr_i,
	input  wire logic [vmc_pkg::REG_DW-1:0]   reg_wdata_i,
	input  wire logic                         reg_wr_i,
	input  wire logic                         reg_rd_i,
	input  wire logic [vmc_pkg::REG_DW-1:0]   reg_rdata_o,
	// Virtual machine view
	input  wire logic                         vm_group0_enable_i,
	input  wire logic                         vm_ack_rd_i,
	input  wire logic                         vm_alias_ack_rd_i,
	input  wire logic [vmc_pkg::LR_ID_W-1:0]  vm_ack_data_o,
	input  wire logic                         vm_ack_valid_o,
	input  wire logic                         vm_irq_o,
	input  wire logic                         maint_irq_o
);
	logic [7:0] c;
	wire logic  ack;

	// Shadow of the software-owned enable bits
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			c <= 8'h00;
		else if (reg_wr_i && reg_addr_i == vmc_pkg::OFS_CTRL)
			c <= reg_wdata_i[7:0];
	end
	assign ack = vm_ack_rd_i || vm_alias_ack_rd_i;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// Enable bits, maintenance output and virtual interrupt
	a_en_off_quiet: assert property (!c[0] |=> !maint_irq_o)
		else $error("maintenance raised while disabled");
	a_g0_off_raise: assert property (
		c[0] && c[5] && !vm_group0_enable_i |=> maint_irq_o)
		else $error("group 0 disabled source missed");
	a_g0_on_raise: assert property (
		c[0] && c[4] && vm_group0_enable_i |=> maint_irq_o)
		else $error("group 0 enabled source missed");
	a_only_g0d_quiet: assert property (
		c[7:1] == 7'h10 && vm_group0_enable_i |=> !maint_irq_o)
		else $error("maintenance without an enabled cause");
	a_vm_irq_gated: assert property (!c[0] |=> !vm_irq_o)
		else $error("virtual interrupt while disabled");
	// Acknowledge reads and control register readback
	a_ack_spurious: assert property (
		ack && !c[0] |=> vm_ack_valid_o && vm_ack_data_o == SPURIOUS_ID)
		else $error("acknowledge while disabled not spurious");
	a_ack_one_pulse: assert property (vm_ack_valid_o == $past(ack))
		else $error("acknowledge valid does not follow its read");
	a_ctrl_readback: assert property (
		reg_rd_i && reg_addr_i == vmc_pkg::OFS_CTRL
		|=> reg_rdata_o[26:0] == {19'h0, $past(c)})
		else $error("control read data wrong");

	// Main scenarios
	cover property (c[0] && maint_irq_o);
	cover property (c[0] && c[5] && !vm_group0_enable_i ##1 maint_irq_o);
	cover property (vm_ack_valid_o && vm_ack_data_o != SPURIOUS_ID);
	cover property (ack && !c[0]);
endmodule

bind vmc_maint_ctrl vmc_maint_ctrl_checker #(.SPURIOUS_ID(SPURIOUS_ID)) u_vmc_maint_ctrl_checker (
	.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.vm_group0_enable_i, .vm_ack_rd_i, .vm_alias_ack_rd_i, .vm_ack_data_o, .vm_ack_valid_o,
	.vm_irq_o, .maint_irq_o
);

`default_nettype wire

// ==== tb/vmc_maint_ctrl_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module vmc_maint_ctrl_tb;
	localparam logic [11:0] CT = vmc_pkg::OFS_CTRL;
	localparam logic [11:0] ST = vmc_pkg::OFS_IRQ_STATUS;
	localparam logic [11:0] MK = vmc_pkg::OFS_IRQ_MASK;
	localparam logic [11:0] LR = vmc_pkg::OFS_LR_BASE;
	logic        ref_clk_i;
	logic        rst_i;
	logic [11:0] reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [31:0] reg_rdata_o;
	logic        g0, g1, ack, alias_rd, eoi, apr;
	logic [9:0]  eoi_id;
	logic [9:0]  vm_ack_data_o;
	logic        vm_ack_valid_o, vm_irq_o, maint_irq_o, irq_o;
	int          fails;
	int          compares;

	// Clock at 50 ns period
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	vmc_maint_ctrl u_vmc_maint_ctrl (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .vm_group0_enable_i(g0),
		.vm_group1_enable_i(g1), .vm_ack_rd_i(ack), .vm_alias_ack_rd_i(alias_rd),
		.vm_ack_data_o(vm_ack_data_o), .vm_ack_valid_o(vm_ack_valid_o), .vm_irq_o(vm_irq_o),
		.eoi_valid_i(eoi), .eoi_id_i(eoi_id), .apr_active_i(apr),
		.maint_irq_o(maint_irq_o), .irq_o(irq_o));
	vmc_vm_model u_vmc_vm_model (.ref_clk_i(ref_clk_i), .grp0_o(g0), .grp1_o(g1), .ack_o(ack),
		.alias_o(alias_rd), .eoi_o(eoi), .eoi_id_o(eoi_id), .apr_o(apr));

	// Verdict and end of run
	task automatic give_verdict;
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	// Register port cycles
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i    <= 1'b0;
		reg_wdata_i <= ~d;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i   <= 1'b0;
		#1 chk("reg_rdata_o", reg_rdata_o, e);
	endtask

	// Let the registered outputs follow their causes
	task automatic settle;
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic mi(input logic e);
		settle();
		chk("maint_irq_o", {31'h0, maint_irq_o}, {31'h0, e});
	endtask

	task automatic ak(input logic al, input logic [9:0] e);
		u_vmc_vm_model.ack(al);
		#1 chk("vm_ack_valid_o", {31'h0, vm_ack_valid_o}, 32'h1);
		chk("vm_ack_data_o", {22'h0, vm_ack_data_o}, {22'h0, e});
	endtask

	// Bounded run
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		fails++;
		give_verdict();
	end

	initial begin
		rst_i = 1'b1;
		{reg_wr_i, reg_rd_i} = 2'h0;
		reg_addr_i = 12'h000;
		reg_wdata_i = 32'h00000000;
		repeat (12) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		// Reset values and an unmapped address
		rd(CT, 32'h00000000);
		rd(ST, 32'h00000000);
		rd(MK, 32'h00000000);
		rd(12'h010, 32'h00000000);
		// All sources enabled but the interface disabled
		wr(LR, 32'h10000005);
		wr(CT, 32'h000000FE);
		mi(0);
		chk("vm_irq_o", {31'h0, vm_irq_o}, 32'h0);
		for (int i = 0; i < 2; i++)
			ak(i[0], 10'h3FF);
		rd(LR, 32'h10000005);
		// Group 0 enable sources
		wr(CT, 32'h00000021);
		mi(1);
		chk("vm_irq_o", {31'h0, vm_irq_o}, 32'h1);
		u_vmc_vm_model.groups(1, 0);
		mi(0);
		wr(CT, 32'h00000011);
		mi(1);
		u_vmc_vm_model.groups(0, 1);
		mi(0);
		// No pending entry left after the acknowledge
		wr(CT, 32'h00000009);
		mi(0);
		ak(0, 10'h005);
		mi(1);
		// One valid, two valid, one valid
		wr(CT, 32'h00000003);
		mi(1);
		wr(LR + 12'h004, 32'h10000009);
		mi(0);
		wr(LR + 12'h004, 32'h00000000);
		mi(1);
		// Unmatched end of interrupt count
		wr(CT, 32'h00000005);
		mi(0);
		u_vmc_vm_model.eoi(10'h007, 0);
		mi(0);
		u_vmc_vm_model.eoi(10'h007, 1);
		mi(1);
		rd(CT, 32'h08000005);
		u_vmc_vm_model.eoi(10'h005, 1);
		rd(CT, 32'h08000005);
		rd(LR, 32'h00000005);
		wr(CT, 32'hF8000005);
		u_vmc_vm_model.eoi(10'h003, 1);
		mi(0);
		rd(CT, 32'h00000005);
		wr(CT, 32'h00000003);
		mi(1);
		// Sticky status, mask, live conditions and interrupt line
		wr(CT, 32'h00000000);
		wr(ST, 32'h000000FF);
		wr(MK, 32'h00000020);
		wr(CT, 32'h00000020);
		mi(0);
		chk("irq_o", {31'h0, irq_o}, 32'h1);
		rd(vmc_pkg::OFS_COND, 32'h00000020);
		u_vmc_vm_model.groups(1, 0);
		rd(ST, 32'h00000020);
		wr(MK, 32'h00000000);
		#1 chk("irq_o", {31'h0, irq_o}, 32'h0);
		wr(MK, 32'h00000020);
		wr(ST, 32'h00000020);
		settle();
		chk("irq_o", {31'h0, irq_o}, 32'h0);
		rd(ST, 32'h00000000);
		give_verdict();
	end
endmodule

`default_nettype wire

// ==== tb/vmc_vm_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module vmc_vm_model (
	// Clock
	input  wire logic       ref_clk_i,
	// Virtual machine side
	output logic            grp0_o,
	output logic            grp1_o,
	output logic            ack_o,
	output logic            alias_o,
	output logic            eoi_o,
	output logic      [9:0] eoi_id_o,
	output logic            apr_o
);
	// Idle levels at time zero
	initial begin
		{grp0_o, grp1_o, ack_o, alias_o, eoi_o, apr_o} = 6'h00;
		eoi_id_o = 10'h000;
	end

	// Group enable levels change just after an edge
	task automatic groups(input logic g0, input logic g1);
		@(posedge ref_clk_i);
		grp0_o <= g0;
		grp1_o <= g1;
	endtask

	// One-cycle acknowledge read, normal or aliased
	task automatic ack(input logic alias_rd);
		@(posedge ref_clk_i);
		ack_o   <= !alias_rd;
		alias_o <= alias_rd;
		@(posedge ref_clk_i);
		ack_o   <= 1'b0;
		alias_o <= 1'b0;
	endtask

	// One-cycle end of interrupt; released id and level do not linger
	task automatic eoi(input logic [9:0] id, input logic apr);
		@(posedge ref_clk_i);
		eoi_o    <= 1'b1;
		eoi_id_o <= id;
		apr_o    <= apr;
		@(posedge ref_clk_i);
		eoi_o    <= 1'b0;
		eoi_id_o <= ~id;
		apr_o    <= ~apr;
	endtask
endmodule

`default_nettype wire
